//--- avs_pkg.sv
package avs_pkg;
    // Base portion of the system time clock
    localparam int TS_W = 33;
    localparam int TAG_W = 16;
    // 100 MHz to 90 kHz by a phase accumulator: add 9 per cycle, wrap at 10000
    localparam int CLK_HZ = 100000000;
    localparam int BASE_HZ = 90000;
    localparam logic [13:0] PHASE_STEP = 14'(BASE_HZ / 10000);
    localparam logic [13:0] PHASE_WRAP = 14'(CLK_HZ / 10000);
    // Picture increment for 29,97 Hz video in 90 kHz ticks
    localparam logic [32:0] VIDEO_INCR_2997 = 33'h0_0000_0BBB;
    localparam logic [32:0] TS_RESET = 33'h0_0000_0000;
    // Access unit word layout
    localparam int AU_TAG_LSB = 0;
    localparam int AU_DTS_LSB = 16;
    localparam int AU_PTS_LSB = 49;
    localparam int AU_HAS_DTS = 82;
    localparam int AU_HAS_PTS = 83;
    localparam int AU_REORDER = 84;
    localparam int AU_VIDEO = 85;
    localparam int AU_W = 86;
    localparam int BUF_DEPTH = 2;
    typedef enum logic [1:0] {AVS_IDLE, AVS_WAIT, AVS_ISSUE} avs_state_t;
endpackage

//--- avs_skid_buf.sv
`timescale 1ns/10ps
`default_nettype none
module avs_skid_buf #(
    parameter int WIDTH = avs_pkg::AU_W
) (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    logic [WIDTH-1:0] mem [avs_pkg::BUF_DEPTH];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    logic push;
    logic pop;

    // Honest flags: ready drops only when both words are held
    assign o_ready = (count != 2'(avs_pkg::BUF_DEPTH));
    assign o_valid = (count != 2'h0);
    assign o_data = mem[rd_ptr];
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;

    // Storage, no reset needed for data
    always_ff @(posedge i_mclk) begin
        if (push) begin
            mem[wr_ptr] <= i_data;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule // avs_skid_buf
`default_nettype wire

//--- avs_scheduler.sv
`timescale 1ns/10ps
`default_nettype none
module avs_scheduler (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    // Clock base load from an external recovery loop
    input wire logic i_stc_load,
    input wire logic [32:0] i_stc_value,
    // Timing setup
    input wire logic [32:0] i_decode_offset,
    input wire logic [32:0] i_display_offset,
    input wire logic i_video_is_2997,
    input wire logic [32:0] i_video_incr,
    input wire logic [32:0] i_audio_incr,
    input wire logic i_video_locked,
    input wire logic i_audio_locked,
    // Access units from the demultiplexer
    input wire logic i_au_valid,
    output logic o_au_ready,
    input wire logic i_au_video,
    input wire logic i_au_reorder,
    input wire logic i_au_has_pts,
    input wire logic i_au_has_dts,
    input wire logic [32:0] i_au_pts,
    input wire logic [32:0] i_au_dts,
    input wire logic [15:0] i_au_tag,
    // Decode release
    output logic o_dec_valid,
    input wire logic i_dec_ready,
    output logic o_dec_video,
    output logic [15:0] o_dec_tag,
    output logic o_dec_estimated,
    // Presentation strobes and clock base
    output logic o_apres_pulse,
    output logic [15:0] o_apres_tag,
    output logic o_vpres_pulse,
    output logic [15:0] o_vpres_tag,
    output logic [32:0] o_stc
);
    logic [13:0] phase;
    logic tick;
    logic [32:0] stc;
    logic buf_valid;
    logic buf_ready;
    logic [avs_pkg::AU_W-1:0] buf_data;
    avs_pkg::avs_state_t state;
    logic [32:0] last_dts [2];
    logic [32:0] due_dts;
    logic [32:0] due_pts;
    logic cur_video;
    logic cur_reorder;
    logic cur_est;
    logic [15:0] cur_tag;
    // Presentation slots: audio, video pending, video delay store
    logic a_full;
    logic [32:0] a_pts;
    logic [15:0] a_tag;
    logic v_full;
    logic [32:0] v_pts;
    logic [15:0] v_tag;
    logic h_full;
    logic [32:0] h_pts;
    logic [15:0] h_tag;
    logic [32:0] incr;
    logic [32:0] next_dts;
    logic [32:0] next_pts;
    logic slot_free;
    logic dec_take;
    logic a_due;
    logic v_due;
    logic h_due;

    // Reached when clock minus stamp lies in the forward half of the ring
    function automatic logic is_due(input logic [32:0] clk_now, input logic [32:0] ts);
        logic [32:0] diff;
        diff = clk_now - ts;
        return ~diff[32];
    endfunction

    // 90 kHz enable, exact on average with no second clock
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            phase <= 14'h0000;
            tick <= 1'b0;
        end else if (phase + avs_pkg::PHASE_STEP >= avs_pkg::PHASE_WRAP) begin
            phase <= phase + avs_pkg::PHASE_STEP - avs_pkg::PHASE_WRAP;
            tick <= 1'b1;
        end else begin
            phase <= phase + avs_pkg::PHASE_STEP;
            tick <= 1'b0;
        end
    end

    // Shared 33-bit base counter, wraps naturally
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            stc <= avs_pkg::TS_RESET;
        end else if (i_stc_load) begin
            stc <= i_stc_value;
        end else if (tick) begin
            stc <= stc + 33'h0_0000_0001;
        end
    end
    assign o_stc = stc;

    // Two words of slack so a stalled decoder loses nothing
    avs_skid_buf #(.WIDTH(avs_pkg::AU_W)) u_buf (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .i_valid(i_au_valid),
        .o_ready(o_au_ready),
        .i_data({i_au_video, i_au_reorder, i_au_has_pts, i_au_has_dts,
                 i_au_pts, i_au_dts, i_au_tag}),
        .o_valid(buf_valid),
        .i_ready(buf_ready),
        .o_data(buf_data)
    );
    assign buf_ready = (state == avs_pkg::AVS_IDLE);

    // Stamp derivation for the unit at the buffer head
    always_comb begin
        logic hv;
        hv = buf_data[avs_pkg::AU_VIDEO];
        if (hv) begin
            incr = i_video_is_2997 ? avs_pkg::VIDEO_INCR_2997 : i_video_incr;
        end else begin
            incr = i_audio_incr;
        end
        if (buf_data[avs_pkg::AU_HAS_DTS]) begin
            next_dts = buf_data[avs_pkg::AU_DTS_LSB +: 33];
        end else if (buf_data[avs_pkg::AU_HAS_PTS]) begin
            next_dts = buf_data[avs_pkg::AU_PTS_LSB +: 33];
        end else begin
            next_dts = last_dts[hv] + incr;
        end
        if (buf_data[avs_pkg::AU_HAS_PTS]) begin
            next_pts = buf_data[avs_pkg::AU_PTS_LSB +: 33];
        end else if (buf_data[avs_pkg::AU_REORDER]) begin
            next_pts = next_dts + incr;
        end else begin
            next_pts = next_dts;
        end
    end

    // Capture head; decode offset moves both stamps, display offset only the presentation one
    // Holding release by the offset means the coded buffer upstream needs rate/picture-rate more
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            due_dts <= avs_pkg::TS_RESET;
            due_pts <= avs_pkg::TS_RESET;
            cur_video <= 1'b0;
            cur_reorder <= 1'b0;
            cur_est <= 1'b0;
            cur_tag <= 16'h0000;
            last_dts[0] <= avs_pkg::TS_RESET;
            last_dts[1] <= avs_pkg::TS_RESET;
        end else if (buf_valid && buf_ready) begin
            due_dts <= next_dts + i_decode_offset;
            due_pts <= next_pts + i_decode_offset + i_display_offset;
            cur_video <= buf_data[avs_pkg::AU_VIDEO];
            cur_reorder <= buf_data[avs_pkg::AU_REORDER];
            cur_est <= !(buf_data[avs_pkg::AU_HAS_PTS] || buf_data[avs_pkg::AU_HAS_DTS])
                && !(buf_data[avs_pkg::AU_VIDEO] ? i_video_locked : i_audio_locked);
            cur_tag <= buf_data[avs_pkg::AU_TAG_LSB +: 16];
            last_dts[buf_data[avs_pkg::AU_VIDEO]] <= next_dts;
        end
    end

    // Target slot must be free before the unit leaves for decoding
    assign slot_free = !cur_video ? !a_full : (cur_reorder ? !h_full : !v_full);
    assign dec_take = o_dec_valid && i_dec_ready;

    // Decode release: timing comes from clock and stamps, gated by a free presentation slot
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= avs_pkg::AVS_IDLE;
        end else begin
            case (state)
                avs_pkg::AVS_IDLE: begin
                    if (buf_valid) begin
                        state <= avs_pkg::AVS_WAIT;
                    end
                end
                avs_pkg::AVS_WAIT: begin
                    if (is_due(stc, due_dts) && slot_free) begin
                        state <= avs_pkg::AVS_ISSUE;
                    end
                end
                avs_pkg::AVS_ISSUE: begin
                    if (i_dec_ready) begin
                        state <= avs_pkg::AVS_IDLE;
                    end
                end
                default: begin
                    state <= avs_pkg::AVS_IDLE;
                end
            endcase
        end
    end
    assign o_dec_valid = (state == avs_pkg::AVS_ISSUE);
    assign o_dec_video = cur_video;
    assign o_dec_tag = cur_tag;
    assign o_dec_estimated = cur_est;

    assign a_due = a_full && is_due(stc, a_pts);
    assign v_due = v_full && is_due(stc, v_pts);
    assign h_due = h_full && is_due(stc, h_pts) && !v_due;

    // Presentation slots; a set in the same cycle as a release wins
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            a_full <= 1'b0;
            v_full <= 1'b0;
            h_full <= 1'b0;
            a_pts <= avs_pkg::TS_RESET;
            v_pts <= avs_pkg::TS_RESET;
            h_pts <= avs_pkg::TS_RESET;
            a_tag <= 16'h0000;
            v_tag <= 16'h0000;
            h_tag <= 16'h0000;
        end else begin
            if (a_due) begin
                a_full <= 1'b0;
            end
            if (v_due) begin
                v_full <= 1'b0;
            end
            if (h_due) begin
                h_full <= 1'b0;
            end
            if (dec_take && !cur_video) begin
                a_full <= 1'b1;
                a_pts <= due_pts;
                a_tag <= cur_tag;
            end
            if (dec_take && cur_video && !cur_reorder) begin
                v_full <= 1'b1;
                v_pts <= due_pts;
                v_tag <= cur_tag;
            end
            if (dec_take && cur_video && cur_reorder) begin
                h_full <= 1'b1;
                h_pts <= due_pts;
                h_tag <= cur_tag;
            end
        end
    end

    // Registered presentation strobes; held picture yields to a due pending one
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_apres_pulse <= 1'b0;
            o_apres_tag <= 16'h0000;
            o_vpres_pulse <= 1'b0;
            o_vpres_tag <= 16'h0000;
        end else begin
            o_apres_pulse <= a_due;
            o_vpres_pulse <= v_due || h_due;
            if (a_due) begin
                o_apres_tag <= a_tag;
            end
            if (v_due) begin
                o_vpres_tag <= v_tag;
            end else if (h_due) begin
                o_vpres_tag <= h_tag;
            end
        end
    end
endmodule // avs_scheduler
`default_nettype wire

//--- avs_scheduler_chk.sv
`timescale 1ns/10ps
`default_nettype none
module avs_chk (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_stc_load,
    input wire logic [32:0] i_stc_value,
    input wire logic i_dec_ready,
    input wire logic o_dec_valid,
    input wire logic [15:0] o_dec_tag,
    input wire logic o_apres_pulse,
    input wire logic [15:0] o_apres_tag,
    input wire logic o_vpres_pulse,
    input wire logic [15:0] o_vpres_tag,
    input wire logic [32:0] o_stc
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);
    // Clock base: load wins, otherwise it only steps by one, wrapping mod 2^33
    a_stc_load_value: assert property (i_stc_load |=> o_stc == $past(i_stc_value))
        else $error("clock base missed its load");
    a_stc_step_one: assert property (!$past(i_stc_load) && o_stc != $past(o_stc)
        |-> o_stc == 33'($past(o_stc) + 33'h1)) else $error("clock base jumped");
    // Released unit holds until the decoder takes it, then a gap of two cycles
    a_dec_hold: assert property (o_dec_valid && !i_dec_ready
        |=> o_dec_valid && $stable(o_dec_tag)) else $error("decode release dropped");
    a_dec_gap_after: assert property (o_dec_valid && i_dec_ready |=> !o_dec_valid [*2])
        else $error("decode release too soon");
    a_dec_gap_before: assert property ($rose(o_dec_valid) |-> !$past(o_dec_valid, 2))
        else $error("decode release without gap");
    // Audio strobe is single; both presentation strobes carry their tag with them
    a_apres_single: assert property (o_apres_pulse |=> !o_apres_pulse)
        else $error("audio strobe longer than one cycle");
    a_apres_tag_hold: assert property (!o_apres_pulse |-> $stable(o_apres_tag))
        else $error("audio tag moved without strobe");
    a_vpres_tag_hold: assert property (!o_vpres_pulse |-> $stable(o_vpres_tag))
        else $error("video tag moved without strobe");
endmodule // avs_chk
bind avs_scheduler avs_chk chk_u (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
    .i_stc_load(i_stc_load), .i_stc_value(i_stc_value), .i_dec_ready(i_dec_ready),
    .o_dec_valid(o_dec_valid), .o_dec_tag(o_dec_tag), .o_apres_pulse(o_apres_pulse),
    .o_apres_tag(o_apres_tag), .o_vpres_pulse(o_vpres_pulse), .o_vpres_tag(o_vpres_tag),
    .o_stc(o_stc));
`default_nettype wire

//--- avs_demux_model.sv
`timescale 1ns/10ps
`default_nettype none
module avs_demux_model (
    input wire logic i_mclk,
    input wire logic i_ready,
    output logic o_valid,
    output logic o_video,
    output logic o_reorder,
    output logic o_has_pts,
    output logic o_has_dts,
    output logic [32:0] o_pts,
    output logic [32:0] o_dts,
    output logic [15:0] o_tag
);
    // Idle at time zero
    initial begin
        o_valid = 1'b0;
        {o_video, o_reorder, o_has_pts, o_has_dts, o_pts, o_dts, o_tag} = '0;
    end
    // Called just past a falling edge; valid stays up across back-to-back units
    task automatic send(logic [3:0] f, logic [32:0] p, logic [32:0] d, logic [15:0] t,
        output logic ok);
        int n;
        {o_video, o_reorder, o_has_pts, o_has_dts} = f;
        o_pts = p;
        o_dts = d;
        o_tag = t;
        o_valid = 1'b1;
        n = 0;
        do begin
            @(posedge i_mclk);
            n++;
        end while (!i_ready && n < 500);
        ok = i_ready;
        @(negedge i_mclk);
    endtask
    // Released lines must not keep showing the last unit
    task automatic idle();
        o_valid = 1'b0;
        o_pts = ~o_pts;
        o_dts = ~o_dts;
        o_tag = ~o_tag;
    endtask
endmodule // avs_demux_model
`default_nettype wire

//--- tb_avs_scheduler.sv
`timescale 1ns/10ps
`default_nettype none
module tb_avs_scheduler;
    localparam logic [32:0] DOFS = 33'h0_0000_0010;
    localparam logic [32:0] POFS = 33'h0_0000_0020;
    logic i_mclk = 1'b0;
    logic rst_n = 1'b0;
    logic load = 1'b0;
    logic dec_rdy = 1'b0;
    logic [32:0] load_v = '0, v_incr = '0, a_incr = '0;
    logic v2997 = 1'b1;
    logic vlock = 1'b0;
    logic alock = 1'b1;
    logic av, avid, areo, ahp, ahd, ardy, dv, dvid, dest, ap, vp;
    logic [32:0] apts, adts, stc;
    logic [15:0] atag, dtag, aptag, vptag;
    logic [15:0] t[4];
    logic [17:0] q_dec[$], q_ap[$], q_vp[$];
    int n_mismatch = 0;
    int n_tests = 0;
    avs_scheduler dut_u (.i_mclk(i_mclk), .i_reset_n(rst_n), .i_stc_load(load),
        .i_stc_value(load_v), .i_decode_offset(DOFS), .i_display_offset(POFS),
        .i_video_is_2997(v2997), .i_video_incr(v_incr), .i_audio_incr(a_incr),
        .i_video_locked(vlock), .i_audio_locked(alock), .i_au_valid(av), .o_au_ready(ardy),
        .i_au_video(avid), .i_au_reorder(areo), .i_au_has_pts(ahp), .i_au_has_dts(ahd),
        .i_au_pts(apts), .i_au_dts(adts), .i_au_tag(atag), .o_dec_valid(dv),
        .i_dec_ready(dec_rdy), .o_dec_video(dvid), .o_dec_tag(dtag), .o_dec_estimated(dest),
        .o_apres_pulse(ap), .o_apres_tag(aptag), .o_vpres_pulse(vp), .o_vpres_tag(vptag),
        .o_stc(stc));
    avs_demux_model dm_u (.i_mclk(i_mclk), .i_ready(ardy), .o_valid(av), .o_video(avid),
        .o_reorder(areo), .o_has_pts(ahp), .o_has_dts(ahd), .o_pts(apts), .o_dts(adts),
        .o_tag(atag));
    initial begin
        forever #5 i_mclk = ~i_mclk;
    end
    // Random decoder stalls exercise the hold of a released unit
    always @(negedge i_mclk) dec_rdy <= 1'($urandom);
    // Oldest note against each result; a result with no note is a mismatch
    always @(posedge i_mclk) begin
        if (rst_n && dv && dec_rdy)
            check("decode", {dvid, dest, dtag}, q_dec.size() ? q_dec.pop_front() : 'x);
        if (rst_n && ap)
            check("apres", {2'b00, aptag}, q_ap.size() ? q_ap.pop_front() : 'x);
        if (rst_n && vp)
            check("vpres", {2'b00, vptag}, q_vp.size() ? q_vp.pop_front() : 'x);
    end
    task automatic check(string what, logic [17:0] seen, logic [17:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic set_stc(logic [32:0] v);
        load = 1'b1;
        load_v = v;
        @(negedge i_mclk);
        load = 1'b0;
        load_v = ~v;
    endtask
    task automatic drain(int lim);
        int n;
        n = 0;
        while (q_dec.size() + q_ap.size() + q_vp.size() != 0 && n < lim) begin
            @(negedge i_mclk);
            n++;
        end
        if (n >= lim) begin
            n_mismatch++;
            $display("unexpected drain: expected 0 notes left seen %0d",
                q_dec.size() + q_ap.size() + q_vp.size());
            test_done();
        end
    endtask
    // One tick early nothing may appear; on the due value the result must
    task automatic at(logic [32:0] due, int k, logic [17:0] e);
        // Load held high parks the base, so a stray tick cannot end the early window
        load = 1'b1;
        load_v = due - 33'h1;
        repeat (8) @(negedge i_mclk);
        if (k == 0) q_dec.push_back(e);
        else if (k == 1) q_ap.push_back(e);
        else q_vp.push_back(e);
        set_stc(due);
        drain(60);
    endtask
    task automatic snd(logic [3:0] f, logic [32:0] p, logic [32:0] d, logic [15:0] tg);
        logic ok;
        dm_u.send(f, p, d, tg, ok);
        check("accept", {17'h0, ok}, 18'h1);
    endtask
    initial begin
        repeat (90000) @(posedge i_mclk);
        n_mismatch++;
        $display("unexpected run length: expected under %0d cycles seen %0d", 90000, 90000);
        test_done();
    end
    initial begin
        void'($urandom(32'h4d54));
        // Small free increments, so an interpolated unit never lands behind the clock
        v_incr = 33'h0_0000_0040 + 33'($urandom & 32'h0000_FFFF);
        a_incr = 33'h0_0000_0040 + 33'($urandom & 32'h0000_FFFF);
        for (int i = 0; i < 4; i++) t[i] = 16'($urandom);
        repeat (6) @(posedge i_mclk);
        @(negedge i_mclk);
        rst_n = 1'b1;
        @(negedge i_mclk);
        // One unit waits in the scheduler, two fill the buffer
        for (int i = 0; i < 3; i++) snd(4'b0010, 33'h0_0000_5000, 33'h0, t[i]);
        check("au_ready", {17'h0, ardy}, 18'h0);
        dm_u.idle();
        for (int i = 0; i < 3; i++) begin
            q_dec.push_back({2'b00, t[i]});
            q_ap.push_back({2'b00, t[i]});
        end
        set_stc(33'h0_0000_5100);
        drain(300);
        $display("test buffer done");
        set_stc(33'h0_0000_0100);
        snd(4'b0010, 33'h0_0000_0200, 33'h0_0000_0123, t[3]);
        dm_u.idle();
        at(33'h0_0000_0210, 0, {2'b00, t[3]});
        at(33'h0_0000_0230, 1, {2'b00, t[3]});
        $display("test stamp done");
        // Reordered picture, then an unstamped one on an unlocked clock
        snd(4'b1111, 33'h0_0000_0400, 33'h0_0000_0300, t[0]);
        snd(4'b1000, 33'($urandom), 33'($urandom), t[1]);
        dm_u.idle();
        at(33'h0_0000_0310, 0, {2'b10, t[0]});
        at(33'h0_0000_0430, 2, {2'b00, t[0]});
        at(33'h0_0000_0ECB, 0, {2'b11, t[1]});
        at(33'h0_0000_0EEB, 2, {2'b00, t[1]});
        $display("test interpolate done");
        // Due time sits just past the wrap; load held high parks the base meanwhile
        load = 1'b1;
        load_v = 33'h1_FFFF_FFFF;
        snd(4'b0010, 33'h1_FFFF_FFF0, 33'h0, t[2]);
        dm_u.idle();
        repeat (8) @(negedge i_mclk);
        load = 1'b0;
        q_dec.push_back({2'b00, t[2]});
        drain(2500);
        at(33'h0_0000_0020, 1, {2'b00, t[2]});
        $display("test wrap done");
        // Free increments; audio clock unlocked, video clock locked
        v2997 = 1'b0;
        vlock = 1'b1;
        alock = 1'b0;
        snd(4'b0010, 33'h0_0000_0600, 33'h0, t[3]);
        snd(4'b0000, 33'($urandom), 33'($urandom), t[2]);
        dm_u.idle();
        at(33'h0_0000_0610, 0, {2'b00, t[3]});
        at(33'h0_0000_0630, 1, {2'b00, t[3]});
        at(33'h0_0000_0610 + a_incr, 0, {2'b01, t[2]});
        at(33'h0_0000_0630 + a_incr, 1, {2'b00, t[2]});
        snd(4'b1010, 33'h0_0002_0000, 33'h0, t[0]);
        snd(4'b1000, 33'($urandom), 33'($urandom), t[1]);
        dm_u.idle();
        at(33'h0_0002_0010, 0, {2'b10, t[0]});
        at(33'h0_0002_0030, 2, {2'b00, t[0]});
        at(33'h0_0002_0010 + v_incr, 0, {2'b10, t[1]});
        at(33'h0_0002_0030 + v_incr, 2, {2'b00, t[1]});
        $display("test increment done");
        test_done();
    end
endmodule // tb_avs_scheduler
`default_nettype wire
